// file: src/sync_serial_port.sv
// serial port block: spi shift engine, status and control registers
// assumes an APB master on clk_sys and a two-wire engine beside it
`include "ssp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port (
    // system
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic      [31:0]           prdata,
    // serial pins
    input  wire logic                  sckIn,
    input  wire logic                  sdiIn,
    input  wire logic                  slaveSelectN,
    output logic                       sckOut,
    output logic                       sckOe,
    output logic                       sdoOut,
    output logic                       sdoOe,
    // two-wire engine
    input  wire ssp_pkg::i2c_event_type i2cEvent,
    output logic                       slewLimitOn,
    output logic                       smbusLevels
);
    ssp_pkg::control_type  control;
    ssp_pkg::control_type  next_control;
    ssp_pkg::status_type   status;
    ssp_pkg::status_type   next_status;
    ssp_pkg::eng_state_type state;
    ssp_pkg::eng_state_type next_state;
    logic [2:0]  pinS;
    logic        divTick;
    logic [7:0]  halfCount;
    logic [7:0]  txShift;
    logic [7:0]  next_txShift;
    logic [7:0]  rxShift;
    logic [7:0]  next_rxShift;
    logic [7:0]  rxBuf;
    logic [7:0]  next_rxBuf;
    logic [4:0]  tickNum;
    logic [4:0]  next_tickNum;
    logic [3:0]  rxCount;
    logic [3:0]  next_rxCount;
    logic        sckPrev;
    logic        next_sckOut;
    logic        next_sdoOut;
    logic        next_sckOe;
    logic        next_sdoOe;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;
    logic        activity;
    logic        next_activity;
    logic        next_slew;
    logic        next_smbus;
    logic        spiDone;
    logic        spiOn;
    logic        i2cOn;
    logic        isMaster;
    logic        ssMode;
    logic        slaveActive;
    logic        sckEdge;
    logic        leadEdge;
    logic        txTick;
    logic        rxTick;
    logic        wrFire;
    logic        rdFire;
    logic        bufWrite;
    logic        bufRead;
    logic        hit;

    // pins from outside the clock domain
    pin_sync #(.W(3)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   ({sckIn, sdiIn, slaveSelectN}),
        .pinOut  (pinS)
    );

    // rate applies only to master modes
    always_comb begin
        unique case (control.mode)
            `SSP_MODE_DIV16:  halfCount = `SSP_HALF_DIV16;
            `SSP_MODE_DIV64:  halfCount = `SSP_HALF_DIV64;
            `SSP_MODE_DIV128: halfCount = `SSP_HALF_DIV128;
            default:          halfCount = `SSP_HALF_DIV4;
        endcase
    end

    sck_divider u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .run       (state == ssp_pkg::SHIFT),
        .halfCount (halfCount),
        .tick      (divTick)
    );

    // mode decode
    assign spiOn    = control.enable & ~control.mode[3];
    assign i2cOn    = control.enable & control.mode[3];
    assign isMaster = (control.mode[3:2] == 2'b00);
    assign ssMode   = (control.mode == `SSP_MODE_SLV_SS);
    assign slaveActive = ~ssMode | ~pinS[0];
    assign sckEdge  = (pinS[2] != sckPrev);
    assign leadEdge = sckEdge & (pinS[2] != control.polarity);

    // bus strobes, effects land on the access edge only
    assign wrFire   = psel & penable & pready & pwrite;
    assign rdFire   = psel & penable & pready & ~pwrite;
    assign bufWrite = wrFire & (paddr == `SSP_ADDR_BUFFER);
    assign bufRead  = rdFire & (paddr == `SSP_ADDR_BUFFER);
    assign hit      = (paddr == `SSP_ADDR_CONTROL)
                    | (paddr == `SSP_ADDR_STATUS)
                    | (paddr == `SSP_ADDR_BUFFER)
                    | (paddr == `SSP_ADDR_ACTIVITY);

    // tx and rx moments; edge bit xor polarity picks the edge
    always_comb begin
        if (isMaster) begin
            txTick = divTick & (tickNum[0] != status.clockEdge)
                   & (tickNum != `SSP_LAST_TICK);
            if (status.samplePhase) begin
                rxTick = divTick & (tickNum[0] != status.clockEdge)
                       & (tickNum != 5'h00);
            end else begin
                rxTick = divTick & (tickNum[0] == status.clockEdge)
                       & (tickNum != `SSP_LAST_TICK);
            end
        end else begin
            // slave ignores sample phase, software keeps it clear
            txTick = slaveActive & sckEdge
                   & (leadEdge == status.clockEdge);
            rxTick = slaveActive & sckEdge
                   & (leadEdge == ~status.clockEdge);
        end
    end

    // shift engine next state
    always_comb begin
        next_state   = state;
        next_tickNum = tickNum;
        next_txShift = txShift;
        next_rxShift = rxShift;
        next_rxCount = rxCount;
        next_rxBuf   = rxBuf;
        next_sckOut  = control.polarity;
        next_sdoOut  = sdoOut;
        spiDone      = 1'b0;
        if (rxTick) begin
            next_rxShift = {rxShift[6:0], pinS[1]};
        end
        if (txTick) begin
            next_sdoOut  = txShift[7];
            next_txShift = {txShift[6:0], 1'b0};
        end
        if (!spiOn) begin
            // disabled: engine parked, reconfigure is safe
            next_state   = ssp_pkg::IDLE;
            next_rxCount = 4'h0;
            next_tickNum = 5'h00;
        end else if (isMaster) begin
            unique case (state)
                ssp_pkg::IDLE: begin
                    if (bufWrite) begin
                        next_state   = ssp_pkg::SHIFT;
                        next_tickNum = 5'h00;
                        next_txShift = pwdata[7:0];
                        if (!status.clockEdge) begin
                            next_sdoOut  = pwdata[7];
                            next_txShift = {pwdata[6:0], 1'b0};
                        end
                    end
                end
                ssp_pkg::SHIFT: begin
                    next_sckOut = sckOut;
                    if (divTick) begin
                        next_tickNum = tickNum + 5'h01;
                        if (tickNum == `SSP_LAST_TICK) begin
                            next_state  = ssp_pkg::IDLE;
                            next_sckOut = control.polarity;
                            next_rxBuf  = next_rxShift;
                            spiDone     = 1'b1;
                        end else begin
                            next_sckOut = ~sckOut;
                        end
                    end
                end
            endcase
        end else begin
            next_state = ssp_pkg::IDLE;
            if (!slaveActive) begin
                next_rxCount = 4'h0;
            end else if (rxTick) begin
                if (rxCount == 4'h7) begin
                    next_rxCount = 4'h0;
                    next_rxBuf   = next_rxShift;
                    spiDone      = 1'b1;
                end else begin
                    next_rxCount = rxCount + 4'h1;
                end
            end
            // preload only between bytes; writes mid-byte ignored
            if (bufWrite && rxCount == 4'h0) begin
                next_txShift = pwdata[7:0];
                if (!status.clockEdge) begin
                    next_sdoOut  = pwdata[7];
                    next_txShift = {pwdata[6:0], 1'b0};
                end
            end
        end
        // pins handed over only while enabled
        next_sckOe = spiOn & isMaster;
        next_sdoOe = spiOn & (isMaster | slaveActive);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state   <= ssp_pkg::IDLE;
            tickNum <= 5'h00;
            txShift <= 8'h00;
            rxShift <= 8'h00;
            rxCount <= 4'h0;
            rxBuf   <= 8'h00;
            sckOut  <= 1'b0;
            sdoOut  <= 1'b0;
            sckOe   <= 1'b0;
            sdoOe   <= 1'b0;
            sckPrev <= 1'b0;
        end else begin
            state   <= next_state;
            tickNum <= next_tickNum;
            txShift <= next_txShift;
            rxShift <= next_rxShift;
            rxCount <= next_rxCount;
            rxBuf   <= next_rxBuf;
            sckOut  <= next_sckOut;
            sdoOut  <= next_sdoOut;
            sckOe   <= next_sckOe;
            sdoOe   <= next_sdoOe;
            sckPrev <= pinS[2];
        end
    end

    // registers, flags and bus answer
    always_comb begin
        next_control = control;
        next_status  = status;
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~hit;
        next_prdata  = 32'h0000_0000;
        if (wrFire && paddr == `SSP_ADDR_CONTROL) begin
            next_control = pwdata[7:0] & `SSP_CONTROL_WR_MASK;
        end
        if (wrFire && paddr == `SSP_ADDR_STATUS) begin
            next_status = (status & ~`SSP_STATUS_WR_MASK)
                        | (pwdata[7:0] & `SSP_STATUS_WR_MASK);
        end
        if (!control.enable) begin
            next_status.startSeen = 1'b0;
            next_status.stopSeen  = 1'b0;
        end else if (i2cOn) begin
            if (i2cEvent.startDet) begin
                next_status.startSeen = 1'b1;
                next_status.stopSeen  = 1'b0;
            end
            if (i2cEvent.stopDet) begin
                next_status.stopSeen  = 1'b1;
                next_status.startSeen = 1'b0;
            end
            if (i2cEvent.byteDone) begin
                next_status.dataAddr = i2cEvent.byteIsData;
            end
            if (control.mode == `SSP_MODE_I2C_MST) begin
                next_status.readWrite = i2cEvent.masterTxBusy;
            end else if (i2cEvent.addrMatch) begin
                next_status.readWrite = i2cEvent.rwBit;
            end else if (i2cEvent.startDet | i2cEvent.stopDet
                         | i2cEvent.nackDet) begin
                next_status.readWrite = 1'b0;
            end
            // set wins over the clear in the same cycle
            if (i2cEvent.addrUpdated) begin
                next_status.updateAddr = 1'b0;
            end
            if (i2cEvent.addrUpdateReq) begin
                next_status.updateAddr = 1'b1;
            end
        end
        // buffer full: clears first, sets last so a set wins
        if (bufRead || (i2cOn && i2cEvent.txDataDone)) begin
            next_status.bufferFull = 1'b0;
        end
        if (spiDone || (i2cOn && (i2cEvent.rxDone || bufWrite))) begin
            next_status.bufferFull = 1'b1;
        end
        next_activity = (control.mode == `SSP_MODE_I2C_MST)
                      & (status.readWrite | (|i2cEvent.seqEnables));
        next_slew  = i2cOn & ~status.samplePhase;
        next_smbus = i2cOn & status.clockEdge;
        // read data captured in the setup cycle
        unique case (paddr)
            `SSP_ADDR_CONTROL:  next_prdata = {24'h00_0000, control};
            `SSP_ADDR_STATUS:   next_prdata = {24'h00_0000, status};
            `SSP_ADDR_BUFFER:   next_prdata = {24'h00_0000, rxBuf};
            `SSP_ADDR_ACTIVITY: next_prdata = {31'h0000_0000, activity};
            default:            next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            control     <= `SSP_CONTROL_RESET;
            status      <= `SSP_STATUS_RESET;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0000_0000;
            activity    <= 1'b0;
            slewLimitOn <= 1'b0;
            smbusLevels <= 1'b0;
        end else begin
            control     <= next_control;
            status      <= next_status;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            prdata      <= next_prdata;
            activity    <= next_activity;
            slewLimitOn <= next_slew;
            smbusLevels <= next_smbus;
        end
    end
endmodule // sync_serial_port
`default_nettype wire

// file: src/ssp_defines.svh
// register map, field positions, reset values and rate counts
// assumes a 32-bit APB slave with an 8-bit byte address
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// byte addresses of the four registers
`define SSP_ADDR_CONTROL   8'h90
`define SSP_ADDR_STATUS    8'h94
`define SSP_ADDR_BUFFER    8'h98
`define SSP_ADDR_ACTIVITY  8'h9c

// status register: writable top two bits; write masks and reset values of status and control
`define SSP_STATUS_WR_MASK 8'hc0
`define SSP_STATUS_RESET   8'h00
`define SSP_CONTROL_RESET  8'h00
`define SSP_CONTROL_WR_MASK 8'h3f

// mode field codes (control bits 3:0)
`define SSP_MODE_DIV4      4'h0
`define SSP_MODE_DIV16     4'h1
`define SSP_MODE_DIV64     4'h2
`define SSP_MODE_DIV128    4'h3
`define SSP_MODE_SLV_SS    4'h4
`define SSP_MODE_SLV_NOSS  4'h5
`define SSP_MODE_I2C_MST   4'h8

// serial clock half period in system clocks, per rate
`define SSP_HALF_DIV4      8'h02
`define SSP_HALF_DIV16     8'h08
`define SSP_HALF_DIV64     8'h20
`define SSP_HALF_DIV128    8'h40

// master transfer: 16 clock edges, one tail tick for end sampling
`define SSP_LAST_TICK      5'h10

`endif

// file: src/ssp_pkg.sv
// types shared by the serial port block
// assumes the defines header carries every number
package ssp_pkg;

    // control register layout
    typedef struct packed {
        logic [1:0] spare;
        logic       enable;
        logic       polarity;
        logic [3:0] mode;
    } control_type;

    // status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic samplePhase;
        logic clockEdge;
        logic dataAddr;
        logic stopSeen;
        logic startSeen;
        logic readWrite;
        logic updateAddr;
        logic bufferFull;
    } status_type;

    // events from the two-wire bus engine, same clock
    typedef struct packed {
        logic       startDet;
        logic       stopDet;
        logic       nackDet;
        logic       byteDone;
        logic       byteIsData;
        logic       addrMatch;
        logic       rwBit;
        logic       addrUpdateReq;
        logic       addrUpdated;
        logic       masterTxBusy;
        logic [4:0] seqEnables;
        logic       rxDone;
        logic       txDataDone;
    } i2c_event_type;

    typedef enum logic [1:0] {
        IDLE  = 2'b01,
        SHIFT = 2'b10
    } eng_state_type;

endpackage

// file: src/pin_sync.sv
// three-stage synchroniser with agreement filter
// assumes inputs asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 3
) (
    // system
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // pins and filtered result
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_pinOut;

    // accept a change only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_pinOut[i] = (stage2[i] == stage3[i]) ? stage3[i]
                                                      : pinOut[i];
        end
    end

    // stage1 feeds stage2 only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            pinOut <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            pinOut <= next_pinOut;
        end
    end
endmodule // pin_sync
`default_nettype wire

// file: src/sck_divider.sv
// serial clock rate divider, emits one-cycle half-period ticks
// assumes halfCount is at least one and held while run is high
`timescale 1ns/1ps
`default_nettype none
module sck_divider (
    // system
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [7:0] halfCount,
    // enable pulse
    output logic            tick
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_tick;

    // restart from zero whenever run drops
    always_comb begin
        next_count = 8'h00;
        next_tick  = 1'b0;
        if (run) begin
            if (count == halfCount - 8'h01) begin
                next_tick = 1'b1;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule // sck_divider
`default_nettype wire

// file: tb/ssp_properties.sv
// port checker for the serial port block
// assumes a bind onto sync_serial_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ssp_properties (
    // system
    input wire logic        clk_sys,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // pins and two-wire levels
    input wire logic        sckOut,
    input wire logic        sckOe,
    input wire logic        sdoOe,
    input wire logic        slewLimitOn,
    input wire logic        smbusLevels
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] ctl;
    logic [7:0] stat;
    logic [1:0] age;
    logic [4:0] edges;
    logic       wr;
    logic       mst;
    logic       twi;
    assign wr  = psel && penable && pready && pwrite;
    assign mst = ctl[5] && ctl[3:0] < 4'h4;
    assign twi = ctl[5] && ctl[3];
    // shadow of settings; age lets registered outputs settle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl   <= 8'h00;
            stat  <= 8'h00;
            age   <= 2'h0;
            edges <= 5'h00;
        end else begin
            if (wr && paddr == 8'h90) ctl <= pwdata[7:0] & 8'h3f;
            if (wr && paddr == 8'h94) stat <= pwdata[7:0] & 8'hc0;
            if (wr && paddr inside {8'h90, 8'h94}) age <= 2'h0;
            else if (age != 2'h3) age <= age + 2'h1;
            // clock edges since the last load or reconfigure
            if (wr && paddr inside {8'h90, 8'h98}) edges <= 5'h00;
            else if (sckOut != $past(sckOut)) edges <= edges + 5'h01;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_settled;
        age == 2'h3;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (s_setup and
        !(paddr inside {8'h90, 8'h94, 8'h98, 8'h9c})
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_master_drives_clk: assert property (s_settled |-> sckOe == mst)
        else $error("clock drive wrong for mode");
    a_slew_limit: assert property (s_settled |->
        slewLimitOn == (twi && !stat[7]))
        else $error("slew limit wrong");
    a_smbus_level: assert property (s_settled |->
        smbusLevels == (twi && stat[6]))
        else $error("input level select wrong");
    a_idle_pins_off: assert property (s_settled and !ctl[5] |->
        !sckOe && !sdoOe)
        else $error("pins driven while disabled");
    a_sck_edges_max: assert property (edges <= 5'h10)
        else $error("more than sixteen clock edges");
endmodule // ssp_properties
`default_nettype wire

// file: tb/spi_peer_model.sv
// spi peripheral facing the master pins of the block
// assumes sck and sdo change only on clk_sys edges
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
    // system
    input  wire logic       clk_sys,
    // link settings and stimulus
    input  wire logic       clock_polarity_bit,
    input  wire logic       cke,
    input  wire logic       arm,
    input  wire logic [7:0] txByte,
    // pins
    input  wire logic       sck,
    input  wire logic       sdo,
    output logic            sdi,
    // results
    output logic      [7:0] rxByte,
    output logic      [4:0] edgeCount
);
    logic       prevSck;
    logic [3:0] k;
    initial begin
        sdi       = 1'h0;
        prevSck   = 1'h0;
        k         = 4'h0;
        rxByte    = 8'h00;
        edgeCount = 5'h00;
    end
    // shift on the transmit edge, capture on the other one
    always @(posedge clk_sys) begin
        prevSck <= sck;
        if (arm) begin
            k         <= 4'h0;
            sdi       <= txByte[7];
            edgeCount <= 5'h00;
        end else if (sck != prevSck) begin
            edgeCount <= edgeCount + 5'h01;
            if (sck == (clock_polarity_bit ^ cke)) begin
                // with cke low, past the frame the line shows the inverse
                sdi <= (edgeCount == 5'h0f) ? !sdi : txByte[3'h7 - k[2:0]];
            end else begin
                rxByte <= {rxByte[6:0], sdo};
                k      <= k + 4'h1;
            end
        end
    end
endmodule // spi_peer_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the serial port block
// assumes the checker and the peer model are compiled first
`include "ssp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] CT = `SSP_ADDR_CONTROL;
    localparam logic [7:0] ST = `SSP_ADDR_STATUS;
    localparam logic [7:0] BU = `SSP_ADDR_BUFFER;
    localparam logic [7:0] AC = `SSP_ADDR_ACTIVITY;
    localparam logic [7:0] SLV = 8'hc6;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, txPeer, rxPeer;
    logic [31:0] pwdata, prdata, q;
    logic        sckIn, sdiIn, slaveSelectN, sckOut, sckOe, sdoOut;
    logic        sdoOe, slewLimitOn, smbusLevels, err;
    logic        clock_polarity_bit, cke, arm, slv, tbSdi, peerSdi;
    logic [4:0]  edgeCount;
    ssp_pkg::i2c_event_type ev;
    int          failures = 0;
    int          checkCount = 0;
    assign sdiIn = slv ? tbSdi : peerSdi;
    sync_serial_port i_dut (.clk_sys, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .pslverr, .prdata, .sckIn, .sdiIn,
        .slaveSelectN, .sckOut, .sckOe, .sdoOut, .sdoOe,
        .i2cEvent(ev), .slewLimitOn, .smbusLevels);
    spi_peer_model i_peer (.clk_sys, .clock_polarity_bit, .cke, .arm, .txByte(txPeer),
        .sck(sckOut), .sdo(sdoOut), .sdi(peerSdi), .rxByte(rxPeer),
        .edgeCount);
    // clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 20);
        q = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(q, e);
    endtask
    task automatic wait_bf;
        int n;
        n = 0;
        do begin
            apb(1'h0, ST, 32'h0);
            n++;
        end while (q[0] !== 1'h1 && n < 200);
        check(q[0], 1'h1);
    endtask
    task automatic clr_ev;
        @(posedge clk_sys);
        ev <= '0;
        @(posedge clk_sys);
    endtask
    task automatic t_regs;
        rd(ST, 32'h0);
        rd(AC, 32'h0);
        wr(ST, 32'hff);
        rd(ST, 32'hc0);
        wr(ST, 32'h0);
        rd(8'ha0, 32'h0);
        check(err, 1'h1);
    endtask
    // master transfer in mode i: polarity i[1], edge i[0]
    task automatic t_spi(input logic [1:0] i);
        logic [7:0]  tx;
        logic [31:0] sv;
        tx = 8'ha5 ^ {6'h0, i};
        sv = {24'h0, i[1] ^ i[0], i[0], 6'h0};
        wr(CT, 32'h0);
        wr(ST, sv);
        wr(CT, {27'h0, i[1], i[0] ? 4'h1 : 4'h2});
        wr(CT, {26'h0, 1'h1, i[1], i[0] ? 4'h1 : 4'h2});
        clock_polarity_bit    <= i[1];
        cke    <= i[0];
        txPeer <= 8'h3c + {6'h0, i};
        @(posedge clk_sys);
        arm <= 1'h1;
        @(posedge clk_sys);
        arm <= 1'h0;
        wr(BU, {24'h0, tx});
        wait_bf;
        rd(BU, {24'h0, 8'h3c + {6'h0, i}});
        check(rxPeer, tx);
        check(edgeCount, 5'h10);
        check(sckOut, i[1]);
        rd(ST, sv);
    endtask
    // slave receive on a bench-made clock, stopped outside the frame
    task automatic t_slave;
        int b;
        wr(CT, 32'h0);
        wr(ST, 32'h40);
        wr(CT, 32'h25);
        slv <= 1'h1;
        for (b = 7; b >= 0; b--) begin
            tbSdi <= SLV[b];
            sckIn <= 1'h1;
            repeat (8) @(posedge clk_sys);
            sckIn <= 1'h0;
            repeat (8) @(posedge clk_sys);
        end
        tbSdi <= !tbSdi;
        wait_bf;
        rd(BU, {24'h0, SLV});
        slv <= 1'h0;
    endtask
    task automatic t_i2c;
        wr(CT, 32'h0);
        wr(ST, 32'h0);
        wr(CT, 32'h28);
        ev.startDet <= 1'h1;
        clr_ev;
        rd(ST, 32'h08);
        ev.byteDone   <= 1'h1;
        ev.byteIsData <= 1'h1;
        clr_ev;
        rd(ST, 32'h28);
        ev.byteDone <= 1'h1;
        clr_ev;
        rd(ST, 32'h08);
        ev.addrUpdateReq <= 1'h1;
        clr_ev;
        rd(ST, 32'h0a);
        ev.addrUpdated <= 1'h1;
        clr_ev;
        rd(ST, 32'h08);
        ev.stopDet <= 1'h1;
        clr_ev;
        rd(ST, 32'h10);
        ev.masterTxBusy <= 1'h1;
        @(posedge clk_sys);
        rd(ST, 32'h14);
        rd(AC, 32'h1);
        ev.masterTxBusy <= 1'h0;
        ev.seqEnables   <= 5'h10;
        @(posedge clk_sys);
        rd(ST, 32'h10);
        rd(AC, 32'h1);
        ev.seqEnables <= 5'h00;
        @(posedge clk_sys);
        rd(AC, 32'h0);
        ev.rxDone <= 1'h1;
        clr_ev;
        rd(ST, 32'h11);
        apb(1'h0, BU, 32'h0);
        rd(ST, 32'h10);
        wr(BU, 32'h55);
        rd(ST, 32'h11);
        ev.txDataDone <= 1'h1;
        clr_ev;
        rd(ST, 32'h10);
        wr(CT, 32'h08);
        apb(1'h0, ST, 32'h0);
        check(q & 32'h18, 32'h0);
        wr(ST, 32'hc0);
        wr(CT, 32'h29);
        ev.addrMatch <= 1'h1;
        ev.rwBit     <= 1'h1;
        clr_ev;
        apb(1'h0, ST, 32'h0);
        check(q & 32'h04, 32'h04);
        ev.nackDet <= 1'h1;
        clr_ev;
        apb(1'h0, ST, 32'h0);
        check(q & 32'h04, 32'h0);
    endtask
    // hang guard, far above the expected run length
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        finish_test;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 43'h0};
        {sckIn, slaveSelectN, clock_polarity_bit, cke, arm, slv, tbSdi} = 7'h20;
        txPeer = 8'h00;
        ev = '0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        t_regs;
        for (int i = 0; i < 4; i++) t_spi(i[1:0]);
        t_slave;
        t_i2c;
        finish_test;
    end
endmodule // tb
bind sync_serial_port ssp_properties i_props (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .sckOut, .sckOe, .sdoOe, .slewLimitOn, .smbusLevels);
`default_nettype wire
